//--- ppc_pkg.sv
`default_nettype none
package ppc_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] PPC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PPC_ADDR_PING_WAIT = 8'h04;
  localparam logic [7:0] PPC_ADDR_GAP_WAIT = 8'h08;
  localparam logic [7:0] PPC_ADDR_MAX_RETRY = 8'h0C;
  localparam logic [7:0] PPC_ADDR_VSTEP = 8'h10;
  localparam logic [7:0] PPC_ADDR_SS_MIN = 8'h14;
  localparam logic [7:0] PPC_ADDR_STATUS = 8'h18;
  localparam logic [7:0] PPC_ADDR_FREQ = 8'h1C;
  localparam logic [7:0] PPC_ADDR_VOLT = 8'h20;
  localparam logic [7:0] PPC_ADDR_IMEAS = 8'h24;
  localparam logic [7:0] PPC_ADDR_EVENTS = 8'h28;

  // ==========================================================================
  // Field positions.
  localparam int PPC_CTRL_EN_BIT = 0;
  localparam int PPC_STAT_ST_LSB = 0;
  localparam int PPC_STAT_RETRY_LSB = 8;
  localparam int PPC_STAT_SS_LSB = 16;
  localparam int PPC_STAT_PWR_BIT = 24;
  localparam int PPC_EVT_FLO_BIT = 0;
  localparam int PPC_EVT_FHI_BIT = 1;
  localparam int PPC_EVT_VLIM_BIT = 2;
  localparam int PPC_EVT_CNT_LSB = 16;

  // ==========================================================================
  // Timing.
  localparam int PPC_CLK_MHZ = 100;
  localparam int PPC_PING_WAIT_MS = 70;
  localparam int PPC_GAP_WAIT_MS = 10;
  localparam int PPC_PING_WAIT_CYC = PPC_PING_WAIT_MS * 1000 * PPC_CLK_MHZ;
  localparam int PPC_GAP_WAIT_CYC = PPC_GAP_WAIT_MS * 1000 * PPC_CLK_MHZ;

  // ==========================================================================
  // Setpoints: frequency in Hz, supply voltage in units of 0.5 mV.
  localparam int PPC_FREQ_PING_HZ = 130000;
  localparam int PPC_FREQ_MIN_HZ = 110000;
  localparam int PPC_FREQ_MAX_HZ = 180000;
  localparam int PPC_VOLT_PING_HMV = 16000;
  localparam int PPC_VOLT_MIN_HMV = 10000;
  localparam int PPC_VOLT_MAX_HMV = 22000;

  // ==========================================================================
  // Loop settings and register reset values.
  localparam int PPC_PROPORTIONAL_GAIN = 1;
  localparam int PPC_INTEGRAL_GAIN = 0;
  localparam int PPC_DERIVATIVE_GAIN = 0;
  localparam int PPC_FREQ_LOOP_OUTPUT_LIMIT = 20000;
  localparam int PPC_VOLT_LOOP_OUTPUT_LIMIT = 1500;
  localparam logic [7:0] PPC_MAX_RETRY_RST = 8'h04;
  localparam logic [15:0] PPC_VSTEP_RST = 16'h0064;
  localparam logic [7:0] PPC_SS_MIN_RST = 8'h40;

  typedef enum logic [4:0] {
    PPC_ST_IDLE = 5'b00001,
    PPC_ST_PING = 5'b00010,
    PPC_ST_GAP = 5'b00100,
    PPC_ST_XFER = 5'b01000,
    PPC_ST_FAIL = 5'b10000
  } ppc_state_t;

endpackage : ppc_pkg
`default_nettype wire

//--- ppc_loop_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ppc_loop_if;
  logic signed [31:0] cur;
  logic signed [31:0] err;
  logic signed [31:0] nxt;
  logic at_lo;
  logic at_hi;
  modport ctl(output cur, output err, input nxt, input at_lo, input at_hi);
  modport step(input cur, input err, output nxt, output at_lo, output at_hi);
endinterface : ppc_loop_if
`default_nettype wire

//--- ppc_loop_step.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_loop_step
  import ppc_pkg::*;
#(
  parameter int LIMIT = 1,
  parameter int LO = 0,
  parameter int HI = 1,
  parameter bit NEG = 1'b0
) (
  ppc_loop_if.step lp
);

  // ==========================================================================
  // Proportional step, output limit, then setpoint clamp.
  logic signed [31:0] term;
  logic signed [31:0] sum;

  always_comb begin
    term = lp.err * 32'(PPC_PROPORTIONAL_GAIN);
    if (term > LIMIT) begin
      term = LIMIT;
    end else if (term < -LIMIT) begin
      term = -LIMIT;
    end
    sum = NEG ? (lp.cur - term) : (lp.cur + term);
    lp.at_lo = 1'b0;
    lp.at_hi = 1'b0;
    if (sum <= LO) begin
      sum = LO;
      lp.at_lo = 1'b1;
    end else if (sum >= HI) begin
      sum = HI;
      lp.at_hi = 1'b1;
    end
    lp.nxt = sum;
  end

endmodule : ppc_loop_step
`default_nettype wire

//--- ppc_top.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_top
  import ppc_pkg::*;
#(
  parameter int PING_WAIT_CYC = PPC_PING_WAIT_CYC,
  parameter int GAP_WAIT_CYC = PPC_GAP_WAIT_CYC
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Packets from the receiver.
  input wire logic ss_valid_i,
  input wire logic [7:0] ss_value_i,
  input wire logic ce_valid_i,
  input wire logic [15:0] target_ma_i,
  // Coil current sense.
  input wire logic [15:0] imeas_ma_i,
  // Inverter and supply setpoints.
  output logic power_on_o,
  output logic [17:0] freq_hz_o,
  output logic [13:0] volt_mv_o
);

  // ==========================================================================
  // State.
  typedef struct packed {
    ppc_state_t st;
    logic [31:0] timer;
    logic [7:0] retries;
    logic [17:0] freq;
    logic [15:0] volt;
    logic [7:0] last_ss;
    logic [15:0] imeas;
    logic [2:0] events;
    logic [15:0] ce_count;
    logic ctrl_en;
    logic [31:0] ping_wait;
    logic [31:0] gap_wait;
    logic [7:0] max_retry;
    logic [15:0] vstep;
    logic [7:0] ss_min;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } ppc_regs_t;

  localparam ppc_regs_t RST_VAL = '{
    st: PPC_ST_IDLE,
    timer: 32'h0000_0000,
    retries: 8'h00,
    freq: 18'(PPC_FREQ_PING_HZ),
    volt: 16'(PPC_VOLT_PING_HMV),
    last_ss: 8'h00,
    imeas: 16'h0000,
    events: 3'h0,
    ce_count: 16'h0000,
    ctrl_en: 1'b0,
    ping_wait: 32'(PING_WAIT_CYC),
    gap_wait: 32'(GAP_WAIT_CYC),
    max_retry: PPC_MAX_RETRY_RST,
    vstep: PPC_VSTEP_RST,
    ss_min: PPC_SS_MIN_RST,
    dp_wr: 1'b0,
    dp_addr: 8'h00,
    rdata: 32'h0000_0000
  };

  ppc_regs_t r_reg;
  ppc_regs_t r_next;

  // ==========================================================================
  // Loop steps.
  ppc_loop_if freq_lp ();
  ppc_loop_if volt_lp ();

  ppc_loop_step #(
    .LIMIT(PPC_FREQ_LOOP_OUTPUT_LIMIT),
    .LO(PPC_FREQ_MIN_HZ),
    .HI(PPC_FREQ_MAX_HZ),
    .NEG(1'b1)
  ) u_freq_step (
    .lp(freq_lp.step)
  );

  ppc_loop_step #(
    .LIMIT(PPC_VOLT_LOOP_OUTPUT_LIMIT),
    .LO(PPC_VOLT_MIN_HMV),
    .HI(PPC_VOLT_MAX_HMV),
    .NEG(1'b0)
  ) u_volt_step (
    .lp(volt_lp.step)
  );

  logic signed [31:0] loop_err;

  // The error is the requested current minus the measured amplitude.
  assign loop_err = $signed({16'h0000, target_ma_i}) - $signed({16'h0000, imeas_ma_i});
  assign freq_lp.cur = $signed({14'h0000, r_reg.freq});
  assign freq_lp.err = loop_err;
  assign volt_lp.cur = $signed({16'h0000, r_reg.volt});
  assign volt_lp.err = loop_err;

  // ==========================================================================
  // Next state.
  logic addr_ok;
  logic [16:0] volt_up;
  logic [31:0] rd;
  logic [31:0] status_w;
  logic [31:0] events_w;

  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign volt_up = {1'b0, r_reg.volt} + {1'b0, r_reg.vstep};

  always_comb begin
    rd = 32'h0000_0000;
    status_w = 32'h0000_0000;
    events_w = 32'h0000_0000;
    r_next = r_reg;
    r_next.imeas = imeas_ma_i;

    // Register writes land in the data phase.
    if (r_reg.dp_wr) begin
      unique case (r_reg.dp_addr)
        PPC_ADDR_CTRL: r_next.ctrl_en = hwdata_i[PPC_CTRL_EN_BIT];
        PPC_ADDR_PING_WAIT: r_next.ping_wait = hwdata_i;
        PPC_ADDR_GAP_WAIT: r_next.gap_wait = hwdata_i;
        PPC_ADDR_MAX_RETRY: r_next.max_retry = hwdata_i[7:0];
        PPC_ADDR_VSTEP: r_next.vstep = hwdata_i[15:0];
        PPC_ADDR_SS_MIN: r_next.ss_min = hwdata_i[7:0];
        PPC_ADDR_EVENTS: r_next.events = r_reg.events & ~hwdata_i[2:0];
        default: r_next.ctrl_en = r_reg.ctrl_en;
      endcase
    end

    // Power sequencing.
    unique case (r_reg.st)
      PPC_ST_IDLE: begin
        if (r_reg.ctrl_en) begin
          r_next.freq = 18'(PPC_FREQ_PING_HZ);
          r_next.volt = 16'(PPC_VOLT_PING_HMV);
          r_next.retries = 8'h00;
          r_next.timer = r_reg.ping_wait;
          r_next.st = PPC_ST_PING;
        end
      end
      PPC_ST_PING: begin
        if (ss_valid_i && (ss_value_i >= r_reg.ss_min)) begin
          r_next.last_ss = ss_value_i;
          r_next.st = PPC_ST_XFER;
        end else if (ss_valid_i || (r_reg.timer == 32'h0000_0000)) begin
          if (ss_valid_i) begin
            r_next.last_ss = ss_value_i;
          end
          r_next.freq = 18'(PPC_FREQ_PING_HZ);
          if (r_reg.retries >= r_reg.max_retry) begin
            r_next.st = PPC_ST_FAIL;
          end else if (volt_up > 17'(PPC_VOLT_MAX_HMV)) begin
            r_next.st = PPC_ST_FAIL;
          end else begin
            r_next.volt = volt_up[15:0];
            r_next.retries = r_reg.retries + 8'h01;
            r_next.timer = r_reg.gap_wait;
            r_next.st = PPC_ST_GAP;
          end
        end else begin
          r_next.timer = r_reg.timer - 32'h0000_0001;
        end
      end
      PPC_ST_GAP: begin
        if (r_reg.timer == 32'h0000_0000) begin
          r_next.timer = r_reg.ping_wait;
          r_next.st = PPC_ST_PING;
        end else begin
          r_next.timer = r_reg.timer - 32'h0000_0001;
        end
      end
      PPC_ST_XFER: begin
        if (ce_valid_i) begin
          r_next.ce_count = r_reg.ce_count + 16'h0001;
          r_next.freq = freq_lp.nxt[17:0];
          if (freq_lp.at_lo || freq_lp.at_hi) begin
            r_next.volt = volt_lp.nxt[15:0];
          end
        end
      end
      PPC_ST_FAIL: begin
        r_next.st = PPC_ST_FAIL;
      end
    endcase

    // Limit events: a new event wins over a clear in the same cycle.
    if ((r_reg.st == PPC_ST_XFER) && ce_valid_i) begin
      if (freq_lp.at_lo) begin
        r_next.events[PPC_EVT_FLO_BIT] = 1'b1;
      end
      if (freq_lp.at_hi) begin
        r_next.events[PPC_EVT_FHI_BIT] = 1'b1;
      end
      if ((freq_lp.at_lo || freq_lp.at_hi) && (volt_lp.at_lo || volt_lp.at_hi)) begin
        r_next.events[PPC_EVT_VLIM_BIT] = 1'b1;
      end
    end

    // Disabling from software stops everything at once.
    if (!r_next.ctrl_en) begin
      r_next.st = PPC_ST_IDLE;
    end

    // Address phase capture.
    r_next.dp_wr = addr_ok && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
    r_next.dp_addr = haddr_i[7:0];

    // Read data is taken from the post-write state so it is always current.
    status_w = 32'({r_next.st}) << PPC_STAT_ST_LSB;
    status_w = status_w | (32'(r_next.retries) << PPC_STAT_RETRY_LSB);
    status_w = status_w | (32'(r_next.last_ss) << PPC_STAT_SS_LSB);
    status_w[PPC_STAT_PWR_BIT] = (r_next.st == PPC_ST_PING) || (r_next.st == PPC_ST_XFER);
    events_w = 32'(r_next.events) | (32'(r_next.ce_count) << PPC_EVT_CNT_LSB);
    if (haddr_i[31:8] == 24'h00_0000) begin
      unique case (haddr_i[7:0])
        PPC_ADDR_CTRL: rd = 32'(r_next.ctrl_en) << PPC_CTRL_EN_BIT;
        PPC_ADDR_PING_WAIT: rd = r_next.ping_wait;
        PPC_ADDR_GAP_WAIT: rd = r_next.gap_wait;
        PPC_ADDR_MAX_RETRY: rd = 32'(r_next.max_retry);
        PPC_ADDR_VSTEP: rd = 32'(r_next.vstep);
        PPC_ADDR_SS_MIN: rd = 32'(r_next.ss_min);
        PPC_ADDR_STATUS: rd = status_w;
        PPC_ADDR_FREQ: rd = 32'(r_next.freq);
        PPC_ADDR_VOLT: rd = 32'(r_next.volt);
        PPC_ADDR_IMEAS: rd = 32'(r_next.imeas);
        PPC_ADDR_EVENTS: rd = events_w;
        default: rd = 32'h0000_0000;
      endcase
    end
    if (addr_ok && !hwrite_i) begin
      r_next.rdata = rd;
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= RST_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs.
  assign hrdata_o = r_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign power_on_o = (r_reg.st == PPC_ST_PING) || (r_reg.st == PPC_ST_XFER);
  assign freq_hz_o = r_reg.freq;
  assign volt_mv_o = r_reg.volt[14:1];

endmodule : ppc_top
`default_nettype wire

//--- ppc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_asserts (
  // Watched ports.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic power_on_o,
  input wire logic [17:0] freq_hz_o,
  input wire logic [13:0] volt_mv_o
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_ping_freq;
    $rose(power_on_o) |-> ##[0:1] freq_hz_o == 18'h1FBD0;
  endproperty
  property p_ping_volt;
    $rose(power_on_o) |-> ##[0:1] volt_mv_o >= 14'h1F40;
  endproperty
  property p_freq_rng;
    freq_hz_o >= 18'h1ADB0 && freq_hz_o <= 18'h2BF20;
  endproperty
  property p_volt_rng;
    volt_mv_o >= 14'h1388 && volt_mv_o <= 14'h2AF8;
  endproperty
  property p_volt_at_edge;
    power_on_o && $past(power_on_o) && $changed(volt_mv_o)
      |-> freq_hz_o == 18'h1ADB0 || freq_hz_o == 18'h2BF20;
  endproperty
  property p_fstep;
    power_on_o && $past(power_on_o) |-> freq_hz_o <= $past(freq_hz_o) + 18'h4E20
      && freq_hz_o + 18'h4E20 >= $past(freq_hz_o);
  endproperty
  property p_vstep;
    power_on_o && $past(power_on_o) |-> volt_mv_o <= $past(volt_mv_o) + 14'h02EE
      && volt_mv_o + 14'h02EE >= $past(volt_mv_o);
  endproperty
  property p_bus_okay;
    hreadyout_o && !hresp_o;
  endproperty
  a_ping_freq: assert property (p_ping_freq) else $error("ping frequency wrong");
  a_ping_volt: assert property (p_ping_volt) else $error("ping supply low");
  a_freq_rng: assert property (p_freq_rng) else $error("frequency out of range");
  a_volt_rng: assert property (p_volt_rng) else $error("supply out of range");
  a_volt_at_edge: assert property (p_volt_at_edge) else $error("supply moved mid range");
  a_fstep: assert property (p_fstep) else $error("frequency step too big");
  a_vstep: assert property (p_vstep) else $error("supply step too big");
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
  c_ping: cover property ($rose(power_on_o));
  c_off: cover property ($fell(power_on_o));
  c_lo: cover property (power_on_o && freq_hz_o == 18'h1ADB0);
endmodule : ppc_asserts
bind ppc_top ppc_asserts u_chk (.clk_sys_i, .rst_n_i, .hreadyout_o, .hresp_o, .power_on_o,
  .freq_hz_o, .volt_mv_o);
`default_nettype wire

//--- ppc_coil_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_coil_model (
  // Power state from the block.
  input wire logic power_on_i,
  // Amplitude chosen by the bench.
  input wire logic [15:0] level_i,
  // Sensed amplitude in mA.
  output logic [15:0] imeas_ma_o
);
  // No coil current flows while the power signal is off.
  assign imeas_ma_o = power_on_i ? level_i : 16'h0000;
endmodule : ppc_coil_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import ppc_pkg::*;
;
  localparam int PW = 20;
  localparam int GW = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ss_valid = 1'b0;
  logic ce_valid = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [7:0] ss_value = 8'h00;
  logic [15:0] target = 16'h0000;
  logic [15:0] level = 16'h0064;
  logic [31:0] hrdata;
  logic hready, hresp, power_on;
  logic [17:0] freq;
  logic [13:0] volt;
  logic [15:0] imeas;
  int miscompares = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  ppc_top #(.PING_WAIT_CYC(PW), .GAP_WAIT_CYC(GW)) uut (.clk_sys_i(clk), .rst_n_i(rst_n),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .ss_valid_i(ss_valid), .ss_value_i(ss_value), .ce_valid_i(ce_valid),
    .target_ma_i(target), .imeas_ma_i(imeas), .power_on_o(power_on), .freq_hz_o(freq),
    .volt_mv_o(volt));
  ppc_coil_model u_coil (.power_on_i(power_on), .level_i(level), .imeas_ma_o(imeas));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask : ahb

  task automatic wait_pwr(input logic v);
    int i;
    i = 0;
    while (power_on !== v && i < 200) begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, power_on}, {31'h0, v}, "power");
  endtask : wait_pwr

  task automatic pulse_ss(input logic [7:0] v);
    ss_value <= v;
    ss_valid <= 1'b1;
    @(posedge clk);
    ss_valid <= 1'b0;
  endtask : pulse_ss

  task automatic pulse_ce(input logic [15:0] t);
    target <= t;
    ce_valid <= 1'b1;
    @(posedge clk);
    ce_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_ce

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    chk({14'h0, freq}, 32'h1FBD0, "reset freq");
    chk({18'h0, volt}, 32'h1F40, "reset volt");
    ahb(1'b0, PPC_ADDR_PING_WAIT, 32'h0);
    chk(rd, PW, "ping wait");
    ahb(1'b0, PPC_ADDR_MAX_RETRY, 32'h0);
    chk(rd, 32'h4, "max retry");
    ahb(1'b0, PPC_ADDR_VSTEP, 32'h0);
    chk(rd, 32'h64, "volt step");
    ahb(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h0, "unmapped");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ping;
    ahb(1'b1, PPC_ADDR_CTRL, 32'h1);
    wait_pwr(1'b1);
    chk({14'h0, freq}, 32'h1FBD0, "ping freq");
    chk({18'h0, volt}, 32'h1F40, "ping volt");
    wait_pwr(1'b0);
    wait_pwr(1'b1);
    chk({14'h0, freq}, 32'h1FBD0, "retry freq");
    chk({18'h0, volt}, 32'h1F72, "retry volt");
    pulse_ss(8'h50);
    repeat (PW + 5) @(posedge clk);
    chk({31'h0, power_on}, 32'h1, "stays on");
    ahb(1'b0, PPC_ADDR_STATUS, 32'h0);
    chk({27'h0, rd[4:0]}, 32'h8, "xfer state");
    $display("t_ping done");
  endtask : t_ping

  task automatic t_loop;
    pulse_ce(16'h13EC);
    chk({14'h0, freq}, 32'h1E848, "freq step");
    chk({18'h0, volt}, 32'h1F72, "volt held");
    pulse_ce(16'h7594);
    chk({14'h0, freq}, 32'h1ADB0, "freq clamp");
    chk({18'h0, volt}, 32'h2260, "volt step");
    pulse_ce(16'h0000);
    chk({14'h0, freq}, 32'h1AE14, "freq back");
    chk({18'h0, volt}, 32'h2260, "volt held");
    ahb(1'b0, PPC_ADDR_EVENTS, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "min event");
    ahb(1'b0, PPC_ADDR_IMEAS, 32'h0);
    chk(rd, {16'h0, level}, "coil current");
    ahb(1'b1, PPC_ADDR_EVENTS, 32'h1);
    ahb(1'b0, PPC_ADDR_EVENTS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0, "min event cleared");
    chk({16'h0, rd[31:16]}, 32'h3, "update count");
    $display("t_loop done");
  endtask : t_loop

  task automatic t_fail;
    ahb(1'b1, PPC_ADDR_CTRL, 32'h0);
    wait_pwr(1'b0);
    ahb(1'b1, PPC_ADDR_VSTEP, 32'h1B58);
    ahb(1'b1, PPC_ADDR_CTRL, 32'h1);
    wait_pwr(1'b1);
    pulse_ss(8'h10);
    wait_pwr(1'b0);
    repeat (PW + GW + 10) @(posedge clk);
    chk({31'h0, power_on}, 32'h0, "stays off");
    ahb(1'b0, PPC_ADDR_STATUS, 32'h0);
    chk({27'h0, rd[4:0]}, 32'h10, "fail state");
    chk({18'h0, volt}, 32'h1F40, "no step");
    $display("t_fail done");
  endtask : t_fail

  task automatic t_retry;
    int n;
    ahb(1'b1, PPC_ADDR_CTRL, 32'h0);
    ahb(1'b1, PPC_ADDR_VSTEP, 32'h64);
    ahb(1'b1, PPC_ADDR_MAX_RETRY, 32'h1);
    ahb(1'b1, PPC_ADDR_GAP_WAIT, 32'h3);
    ahb(1'b1, PPC_ADDR_CTRL, 32'h1);
    wait_pwr(1'b1);
    wait_pwr(1'b0);
    n = 0;
    while (power_on !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(n, 32'h4, "gap length");
    n = 0;
    while (power_on !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(n, PW + 1, "ping length");
    ahb(1'b0, PPC_ADDR_STATUS, 32'h0);
    chk({27'h0, rd[4:0]}, 32'h10, "retry limit state");
    chk({24'h0, rd[15:8]}, 32'h1, "retry count");
    chk({18'h0, volt}, 32'h1F72, "last retry volt");
    $display("t_retry done");
  endtask : t_retry

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ping();
    t_loop();
    t_fail();
    t_retry();
    tally_and_finish();
  end

  initial begin
    #50000;
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
